// *** clks_defs.svh ***
// Register offsets, field positions, reset values and counts of the clock controller.
//
// Functional notes
// - Reject selecting an unready or disabled source; never disable the running source.
// - Every oscillator option has a software-readable ready flag.
// - First prescaler divides system clock by a power of two, 1 to 512.
// - Second and third stages pass or divide; combined factor up to 4.
// - Derived clocks stay phase aligned, glitch free while settings change.
// - New prescaler setting applies at the slowest derived clock's rising edge.
// - Select, prescaler and monitor settings change only through the timed protected write.
// - PLL multiplies its reference by an integer from 1 to 31.
// - PLL reference: 2MHz, 32MHz divided by 4, crystal, or external clock.
// - PLL multiplier and reference cannot change while the PLL is enabled.
// - PLL output is unusable until reference stable and PLL locked.
// - PLL reference oscillator cannot be disabled while the PLL runs.
// - Each frequency loop picks its reference and divides it by 32.
// - Compare values load ideal ratios at reset; the 32MHz one is writable.
// - Enabled loop steps calibration by one when error exceeds half a step.
// - Loop halts in deep sleep, keeps calibration; disabled loop accepts calibration writes.
// - Failure of the running monitored source falls back, resets, flags and raises NMI.
// - Failure of an idle monitored source disables it without NMI.
// - Failure monitor enable sticks until reset.
// - Failure monitor pauses in sleep that stops the sources, restarts on wake.
// - Source switch takes two old-source cycles then two new-source cycles.
// - After reset the 2MHz oscillator runs the system; everything else is off.
`ifndef CLKS_DEFS_SVH
`define CLKS_DEFS_SVH

// Register byte offsets on the APB.
`define CLKS_A_SYSSEL 8'h00
`define CLKS_A_PRESC 8'h04
`define CLKS_A_LOCK 8'h08
`define CLKS_A_OSCEN 8'h0c
`define CLKS_A_OSCSTAT 8'h10
`define CLKS_A_PLLCFG 8'h14
`define CLKS_A_FAILMON 8'h18
`define CLKS_A_D2CTRL 8'h1c
`define CLKS_A_D2CAL 8'h20
`define CLKS_A_D2COMP 8'h24
`define CLKS_A_D32CTRL 8'h28
`define CLKS_A_D32CAL 8'h2c
`define CLKS_A_D32COMP 8'h30
`define CLKS_A_CCP 8'h34

// Source codes; each code is also the bit index of that source's enable.
`define CLKS_SRC_RC2M 3'h0
`define CLKS_SRC_RC32M 3'h1
`define CLKS_SRC_RC32K 3'h2
`define CLKS_SRC_EXTERNAL_OSC_SOURCE 3'h3
`define CLKS_SRC_PLL 3'h4

// Field positions.
`define CLKS_SYSSEL_BUSY 8
`define CLKS_PLLCFG_SRC_LSB 6
`define CLKS_FAIL_PLL 1
`define CLKS_FAIL_EXTERNAL_OSC_SOURCE 0
`define CLKS_FAIL_FLAG_LSB 2

// Reset values.
`define CLKS_OSC_EN_RST 5'h01
`define CLKS_PRESC_RST 7'h00
`define CLKS_PLL_MULT_RST 5'h01
`define CLKS_CAL_RST 8'h40
`define CLKS_COMP2_RST 16'h07a1
`define CLKS_COMP32_RST 16'h7a12

// Protection key, window and counts.
`define CLKS_CCP_KEY 8'h9c
`define CLKS_CCP_WIN 3'h4
`define CLKS_SW_CYC 2'h1
`define CLKS_PSA_MAX 5'h11
`define CLKS_DFLL_DIV 5'h1f
`define CLKS_DFLL_HALF 17'h00004

`endif

// *** clks_pkg.sv ***
// Types shared by the clock controller and its frequency-locked loops.
package clks_pkg;
	typedef enum logic [1:0] {SW_IDLE, SW_OLD, SW_NEW} clks_sw_t;
	typedef struct packed {
		logic [4:0] div;
		logic [15:0] cnt;
		logic armed;
		logic [7:0] cal;
		logic [15:0] comp;
	} clks_dfll_st_t;
endpackage

// *** clks_dfll_if.sv ***
// Carrier between the controller and one frequency-locked loop.
`timescale 1ns/10ps
interface clks_dfll_if;
	logic en;
	logic [1:0] ref_sel;
	logic halt;
	logic [2:0] ref_edge;
	logic osc_edge;
	logic cal_wr;
	logic comp_wr;
	logic [15:0] wdata;
	logic [7:0] cal;
	logic [15:0] comp;
	modport ctl (output en, ref_sel, halt, ref_edge, osc_edge, cal_wr, comp_wr, wdata,
		input cal, comp);
	modport loop (input en, ref_sel, halt, ref_edge, osc_edge, cal_wr, comp_wr, wdata,
		output cal, comp);
endinterface

// *** clks_dfll.sv ***
// Frequency-locked loop that trims one internal oscillator against a 1.024kHz tick.
`timescale 1ns/10ps
`include "clks_defs.svh"
module clks_dfll import clks_pkg::*; #(
	parameter logic [15:0] COMP_RST = `CLKS_COMP2_RST,
	parameter bit COMP_WR = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	clks_dfll_if.loop lp
);
	clks_dfll_st_t s;
	clks_dfll_st_t next_s;
	logic ref_ev;
	logic run;

	// Reference choice: internal 32.768kHz, low-frequency crystal, external clock.
	always_comb begin
		case (lp.ref_sel)
			2'h1: ref_ev = lp.ref_edge[1];
			2'h2: ref_ev = lp.ref_edge[2];
			default: ref_ev = lp.ref_edge[0];
		endcase
	end

	// Oscillator edges are counted over 32 reference edges, then compared.
	always_comb begin
		next_s = s;
		run = lp.en && !lp.halt;
		if (!run) begin
			// Sleep halts the loop but the calibration value is retained.
			next_s.div = 5'h00;
			next_s.cnt = 16'h0000;
			next_s.armed = 1'b0;
			if (lp.cal_wr && !lp.en) begin
				next_s.cal = lp.wdata[7:0];
			end
		end else begin
			if (lp.osc_edge && s.cnt != 16'hffff) begin
				next_s.cnt = s.cnt + 16'h0001;
			end
			if (ref_ev) begin
				next_s.div = s.div + 5'h01;
				if (s.div == `CLKS_DFLL_DIV) begin
					// The first tick only opens a window; it has no full count yet.
					if (s.armed) begin
						if ({1'b0, s.cnt} > {1'b0, s.comp} + `CLKS_DFLL_HALF) begin
							if (s.cal != 8'h00) next_s.cal = s.cal - 8'h01;
						end else if ({1'b0, s.cnt} + `CLKS_DFLL_HALF < {1'b0, s.comp}) begin
							if (s.cal != 8'hff) next_s.cal = s.cal + 8'h01;
						end
					end
					next_s.cnt = {15'h0000, lp.osc_edge};
					next_s.armed = 1'b1;
				end
			end
		end
		if (COMP_WR && lp.comp_wr) begin
			next_s.comp = lp.wdata;
		end
	end

	// State register; compare value reloads its ideal ratio on reset.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '{div: 5'h00, cnt: 16'h0000, armed: 1'b0, cal: `CLKS_CAL_RST,
				comp: COMP_RST};
		end else begin
			s <= next_s;
		end
	end

	assign lp.cal = s.cal;
	assign lp.comp = s.comp;
endmodule

// *** clks_ctrl.sv ***
// System clock selection, prescalers, PLL control, failure monitor and loop control.
`timescale 1ns/10ps
`include "clks_defs.svh"
module clks_ctrl import clks_pkg::*; (
	// Clock and reset.
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	// APB slave.
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// Oscillator status pins: rc2m, rc32m, rc32k, external source ready; PLL lock.
	input wire logic [3:0] OSC_READY_I,
	input wire logic PLL_LOCK_I,
	input wire logic SLEEP_OSC_STOP_I,
	// Raw oscillator clocks seen by the frequency loops.
	input wire logic RC2M_CLK_I,
	input wire logic RC32M_CLK_I,
	input wire logic RC32K_CLK_I,
	input wire logic LOW_FREQ_XTAL_IN_I,
	input wire logic MAIN_XTAL_IN_I,
	// Clock system controls.
	output logic [2:0] SYS_CLK_SOURCE_SELECT_O,
	output logic [4:0] OSC_EN_O,
	output logic [1:0] PLL_SRC_O,
	output logic [4:0] PLL_MULTIPLIER_O,
	output logic PERIPH_CLK_QUAD_EN_O,
	output logic PERIPH_CLK_DOUBLE_EN_O,
	output logic CPU_CORE_CLOCK_EN_O,
	output logic NMI_O,
	output logic [7:0] DFLL2_CAL_O,
	output logic [7:0] DFLL32_CAL_O
);
	typedef struct packed {
		logic [9:0] sync1;
		logic [9:0] sync2;
		logic [4:0] clk_prev;
		logic [2:0] sel;
		logic [2:0] pend;
		clks_sw_t sw;
		logic [1:0] sw_cnt;
		logic [6:0] presc;
		logic [6:0] presc_pend;
		logic presc_upd;
		logic lock;
		logic [4:0] osc_en;
		logic [1:0] pll_src;
		logic [4:0] pll_mult;
		logic [1:0] mon_en;
		logic [1:0] fail;
		logic [1:0] ok_prev;
		logic nmi;
		logic [2:0] ccp_cnt;
		logic [8:0] pa_cnt;
		logic [1:0] pb_cnt;
		logic pc_cnt;
		logic en_quad;
		logic en_double;
		logic en_cpu;
		logic [1:0] dfll_en;
		logic [3:0] dfll_ref;
		logic [31:0] rdata;
	} clks_state_t;

	clks_state_t s;
	clks_state_t next_s;
	clks_dfll_if u_if2 ();
	clks_dfll_if u_if32 ();

	logic apb_wr;
	logic apb_setup_rd;
	logic hit;
	logic prot_ok;
	logic [4:0] rdy;
	logic [4:0] clk_edge;
	logic [4:0] keep;
	logic [2:0] ref_bit;
	logic [3:0] a_exp;
	logic [8:0] a_mask;
	logic [1:0] b_last;
	logic q_ev;
	logic d_ev;
	logic c_ev;
	logic [1:0] fail_ev;
	logic [4:0] psa;
	logic [31:0] rv;

	// Ready flags: stable pin level and the source enabled.
	always_comb begin
		rdy[3:0] = s.sync2[3:0] & s.osc_en[3:0];
		rdy[4] = s.osc_en[4] && s.sync2[4] && s.sync2[ref_bit] && s.osc_en[ref_bit];
		clk_edge = s.sync2[9:5] & ~s.clk_prev;
	end

	// Oscillator feeding the PLL; crystal and external clock share one enable.
	always_comb begin
		case (s.pll_src)
			2'h0: ref_bit = `CLKS_SRC_RC2M;
			2'h1: ref_bit = `CLKS_SRC_RC32M;
			default: ref_bit = `CLKS_SRC_EXTERNAL_OSC_SOURCE;
		endcase
	end

	// Enables that software may not clear right now.
	always_comb begin
		keep = 5'h00;
		keep[s.sel] = 1'b1;
		if (s.sw != SW_IDLE) begin
			keep[s.pend] = 1'b1;
		end
		if (s.osc_en[4]) begin
			keep[ref_bit] = 1'b1;
		end
	end

	// Prescaler stage decode; reserved division codes never reach presc.
	always_comb begin
		if (s.presc[6:2] == 5'h00) begin
			a_exp = 4'h0;
		end else begin
			a_exp = 4'(({1'b0, s.presc[6:2]} + 6'h01) >> 1);
		end
		a_mask = 9'((10'h001 << a_exp) - 10'h001);
		case (s.presc[1:0])
			2'h2: b_last = 2'h3;
			2'h3: b_last = 2'h1;
			default: b_last = 2'h0;
		endcase
		// All three enables come from one counter chain, so they stay aligned.
		q_ev = (s.pa_cnt == a_mask);
		d_ev = q_ev && (s.pb_cnt == b_last);
		c_ev = d_ev && (s.pc_cnt == s.presc[0]);
	end

	// Failure monitor: a good source that drops while watched is a failure.
	always_comb begin
		fail_ev[`CLKS_FAIL_PLL] = s.mon_en[1] && !SLEEP_OSC_STOP_I && s.ok_prev[1]
			&& !s.sync2[4];
		fail_ev[`CLKS_FAIL_EXTERNAL_OSC_SOURCE] = s.mon_en[0] && !SLEEP_OSC_STOP_I && s.ok_prev[0]
			&& !s.sync2[3];
	end

	// APB decode; writes land in the access phase, reads are latched at setup.
	always_comb begin
		apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
		apb_setup_rd = PSEL_I && !PENABLE_I && !PWRITE_I;
		prot_ok = (s.ccp_cnt != 3'h0);
		psa = PWDATA_I[6:2];
		hit = (PADDR_I[1:0] == 2'h0) && (PADDR_I <= `CLKS_A_CCP);
	end

	// Read multiplexer.
	always_comb begin
		rv = 32'h00000000;
		if (PADDR_I == `CLKS_A_SYSSEL) begin
			rv[2:0] = s.sel;
			rv[`CLKS_SYSSEL_BUSY] = (s.sw != SW_IDLE);
		end else if (PADDR_I == `CLKS_A_PRESC) begin
			rv[6:0] = s.presc_pend;
		end else if (PADDR_I == `CLKS_A_LOCK) begin
			rv[0] = s.lock;
		end else if (PADDR_I == `CLKS_A_OSCEN) begin
			rv[4:0] = s.osc_en;
		end else if (PADDR_I == `CLKS_A_OSCSTAT) begin
			rv[4:0] = rdy;
		end else if (PADDR_I == `CLKS_A_PLLCFG) begin
			rv[7:0] = {s.pll_src, 1'b0, s.pll_mult};
		end else if (PADDR_I == `CLKS_A_FAILMON) begin
			rv[3:0] = {s.fail, s.mon_en};
		end else if (PADDR_I == `CLKS_A_D2CTRL) begin
			rv[2:0] = {s.dfll_ref[1:0], s.dfll_en[0]};
		end else if (PADDR_I == `CLKS_A_D2CAL) begin
			rv[7:0] = u_if2.cal;
		end else if (PADDR_I == `CLKS_A_D2COMP) begin
			rv[15:0] = u_if2.comp;
		end else if (PADDR_I == `CLKS_A_D32CTRL) begin
			rv[2:0] = {s.dfll_ref[3:2], s.dfll_en[1]};
		end else if (PADDR_I == `CLKS_A_D32CAL) begin
			rv[7:0] = u_if32.cal;
		end else if (PADDR_I == `CLKS_A_D32COMP) begin
			rv[15:0] = u_if32.comp;
		end
	end

	// Next state of the whole controller.
	always_comb begin
		next_s = s;
		// Two flip-flops on every ready, lock and clock pin before anything looks at it; the sleep input is used unsynchronised.
		next_s.sync1 = {MAIN_XTAL_IN_I, LOW_FREQ_XTAL_IN_I, RC32K_CLK_I, RC32M_CLK_I,
			RC2M_CLK_I, PLL_LOCK_I, OSC_READY_I};
		next_s.sync2 = s.sync1;
		next_s.clk_prev = s.sync2[9:5];
		next_s.nmi = 1'b0;
		if (apb_setup_rd) begin
			next_s.rdata = rv;
		end

		// Protection window counts down and is spent by one protected write.
		if (s.ccp_cnt != 3'h0) begin
			next_s.ccp_cnt = s.ccp_cnt - 3'h1;
		end
		if (apb_wr && PADDR_I == `CLKS_A_CCP) begin
			if (PWDATA_I[7:0] == `CLKS_CCP_KEY) next_s.ccp_cnt = `CLKS_CCP_WIN;
		end

		// Prescaler chain.
		next_s.en_quad = q_ev;
		next_s.en_double = d_ev;
		next_s.en_cpu = c_ev;
		next_s.pa_cnt = q_ev ? 9'h000 : s.pa_cnt + 9'h001;
		if (q_ev) begin
			next_s.pb_cnt = (s.pb_cnt == b_last) ? 2'h0 : s.pb_cnt + 2'h1;
		end
		if (d_ev) begin
			next_s.pc_cnt = (s.pc_cnt == s.presc[0]) ? 1'b0 : 1'b1;
		end
		// Every counter wraps on this edge, so the new ratio starts clean.
		if (c_ev && s.presc_upd) begin
			next_s.presc = s.presc_pend;
			next_s.presc_upd = 1'b0;
		end

		// Source switch: two cycles on the old clock, two on the new one.
		case (s.sw)
			SW_OLD: begin
				next_s.sw_cnt = s.sw_cnt + 2'h1;
				if (s.sw_cnt == `CLKS_SW_CYC) begin
					next_s.sel = s.pend;
					next_s.sw = SW_NEW;
					next_s.sw_cnt = 2'h0;
				end
			end
			SW_NEW: begin
				next_s.sw_cnt = s.sw_cnt + 2'h1;
				if (s.sw_cnt == `CLKS_SW_CYC) begin
					next_s.sw = SW_IDLE;
					next_s.sw_cnt = 2'h0;
				end
			end
			default: begin
				next_s.sw_cnt = 2'h0;
			end
		endcase

		// Register writes.
		if (apb_wr) begin
			if (PADDR_I == `CLKS_A_SYSSEL) begin
				if (prot_ok) next_s.ccp_cnt = 3'h0;
				// A source that is not ready is refused, as is a second switch.
				if (prot_ok && !s.lock && s.sw == SW_IDLE && PWDATA_I[2:0] <= `CLKS_SRC_PLL
					&& PWDATA_I[2:0] != s.sel && rdy[PWDATA_I[2:0]]) begin
					next_s.pend = PWDATA_I[2:0];
					next_s.sw = SW_OLD;
				end
			end else if (PADDR_I == `CLKS_A_PRESC) begin
				if (prot_ok) next_s.ccp_cnt = 3'h0;
				if (prot_ok && !s.lock && (psa == 5'h00 || (psa[0] && psa <= `CLKS_PSA_MAX))) begin
					next_s.presc_pend = PWDATA_I[6:0];
					next_s.presc_upd = 1'b1;
				end
			end else if (PADDR_I == `CLKS_A_LOCK) begin
				if (prot_ok) begin
					next_s.ccp_cnt = 3'h0;
					next_s.lock = s.lock | PWDATA_I[0];
				end
			end else if (PADDR_I == `CLKS_A_OSCEN) begin
				next_s.osc_en = PWDATA_I[4:0] | keep;
			end else if (PADDR_I == `CLKS_A_PLLCFG) begin
				if (!s.osc_en[4] && PWDATA_I[4:0] != 5'h00) begin
					next_s.pll_mult = PWDATA_I[4:0];
					next_s.pll_src = PWDATA_I[7:6];
				end
			end else if (PADDR_I == `CLKS_A_FAILMON) begin
				// Enables only ever set; flags clear by writing one.
				if (prot_ok) begin
					next_s.ccp_cnt = 3'h0;
					next_s.mon_en = s.mon_en | PWDATA_I[1:0];
				end
				next_s.fail = s.fail & ~PWDATA_I[3:2];
			end else if (PADDR_I == `CLKS_A_D2CTRL) begin
				next_s.dfll_en[0] = PWDATA_I[0];
				next_s.dfll_ref[1:0] = PWDATA_I[2:1];
			end else if (PADDR_I == `CLKS_A_D32CTRL) begin
				next_s.dfll_en[1] = PWDATA_I[0];
				next_s.dfll_ref[3:2] = PWDATA_I[2:1];
			end
		end

		// Monitor sees a source as good only while awake and enabled.
		next_s.ok_prev[1] = !SLEEP_OSC_STOP_I && s.osc_en[4] && s.sync2[4];
		next_s.ok_prev[0] = !SLEEP_OSC_STOP_I && s.osc_en[3] && s.sync2[3];

		// Failure handling comes last so that it overrides any write.
		if (fail_ev[1]) begin
			if (s.sel == `CLKS_SRC_PLL || (s.sw != SW_IDLE && s.pend == `CLKS_SRC_PLL)) begin
				next_s.fail[1] = 1'b1;
				next_s.nmi = 1'b1;
			end else begin
				next_s.osc_en[4] = 1'b0;
			end
		end
		if (fail_ev[0]) begin
			if (s.sel == `CLKS_SRC_EXTERNAL_OSC_SOURCE || (s.sw != SW_IDLE && s.pend == `CLKS_SRC_EXTERNAL_OSC_SOURCE)
				|| (s.sel == `CLKS_SRC_PLL && s.osc_en[4] && ref_bit == `CLKS_SRC_EXTERNAL_OSC_SOURCE)) begin
				next_s.fail[0] = 1'b1;
				next_s.nmi = 1'b1;
			end else begin
				next_s.osc_en[3] = 1'b0;
				if (s.osc_en[4] && ref_bit == `CLKS_SRC_EXTERNAL_OSC_SOURCE) next_s.osc_en[4] = 1'b0;
			end
		end
		if (next_s.nmi) begin
			// Fall back to the 2MHz oscillator with default enables.
			next_s.sel = `CLKS_SRC_RC2M;
			next_s.sw = SW_IDLE;
			next_s.sw_cnt = 2'h0;
			next_s.osc_en = `CLKS_OSC_EN_RST;
		end
	end

	// State register; reset starts from the 2MHz oscillator with all else off.
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			s <= '0;
			s.sel <= `CLKS_SRC_RC2M;
			s.pend <= `CLKS_SRC_RC2M;
			s.sw <= SW_IDLE;
			s.osc_en <= `CLKS_OSC_EN_RST;
			s.presc <= `CLKS_PRESC_RST;
			s.presc_pend <= `CLKS_PRESC_RST;
			s.pll_mult <= `CLKS_PLL_MULT_RST;
		end else begin
			s <= next_s;
		end
	end

	// Frequency loop wiring; writes reach the loops in the APB access cycle.
	assign u_if2.en = s.dfll_en[0];
	assign u_if2.ref_sel = s.dfll_ref[1:0];
	assign u_if2.halt = SLEEP_OSC_STOP_I;
	assign u_if2.ref_edge = clk_edge[4:2];
	assign u_if2.osc_edge = clk_edge[0];
	assign u_if2.cal_wr = apb_wr && PADDR_I == `CLKS_A_D2CAL;
	assign u_if2.comp_wr = 1'b0;
	assign u_if2.wdata = PWDATA_I[15:0];
	assign u_if32.en = s.dfll_en[1];
	assign u_if32.ref_sel = s.dfll_ref[3:2];
	assign u_if32.halt = SLEEP_OSC_STOP_I;
	assign u_if32.ref_edge = clk_edge[4:2];
	assign u_if32.osc_edge = clk_edge[1];
	assign u_if32.cal_wr = apb_wr && PADDR_I == `CLKS_A_D32CAL;
	assign u_if32.comp_wr = apb_wr && PADDR_I == `CLKS_A_D32COMP;
	assign u_if32.wdata = PWDATA_I[15:0];

	// Loop for the 2MHz oscillator; its compare value is fixed.
	clks_dfll #(.COMP_RST(`CLKS_COMP2_RST), .COMP_WR(1'b0)) u_dfll2 (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.lp(u_if2.loop)
	);

	// Loop for the 32MHz oscillator; software may retarget it.
	clks_dfll #(.COMP_RST(`CLKS_COMP32_RST), .COMP_WR(1'b1)) u_dfll32 (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.lp(u_if32.loop)
	);

	// Outputs.
	assign PRDATA_O = s.rdata;
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = PSEL_I && PENABLE_I && !hit;
	assign SYS_CLK_SOURCE_SELECT_O = s.sel;
	assign OSC_EN_O = s.osc_en;
	assign PLL_SRC_O = s.pll_src;
	assign PLL_MULTIPLIER_O = s.pll_mult;
	assign PERIPH_CLK_QUAD_EN_O = s.en_quad;
	assign PERIPH_CLK_DOUBLE_EN_O = s.en_double;
	assign CPU_CORE_CLOCK_EN_O = s.en_cpu;
	assign NMI_O = s.nmi;
	assign DFLL2_CAL_O = u_if2.cal;
	assign DFLL32_CAL_O = u_if32.cal;
endmodule

// *** clks_ctrl_asserts.sv ***
// Port-level assertions for the clock controller, bound to its top module.
`timescale 1ns/10ps
module clks_ctrl_asserts (
	// Clock and reset.
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	// PLL status.
	input wire logic PLL_LOCK_I,
	// Clock system controls.
	input wire logic [2:0] SYS_CLK_SOURCE_SELECT_O,
	input wire logic [4:0] OSC_EN_O,
	input wire logic [1:0] PLL_SRC_O,
	input wire logic [4:0] PLL_MULTIPLIER_O,
	input wire logic PERIPH_CLK_QUAD_EN_O,
	input wire logic PERIPH_CLK_DOUBLE_EN_O,
	input wire logic CPU_CORE_CLOCK_EN_O,
	input wire logic NMI_O
);
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (RST_I);
	// The fallback is two steps: defaults at once, then the pulse is gone.
	sequence fallback_s;
		SYS_CLK_SOURCE_SELECT_O == 3'h0 && OSC_EN_O == 5'h01;
	endsequence
	sequence nmi_drop_s;
		fallback_s ##1 !NMI_O;
	endsequence
	chk_sel_range: assert property (SYS_CLK_SOURCE_SELECT_O <= 3'h4)
		else $error("select code out of range");
	chk_run_enabled: assert property (OSC_EN_O[SYS_CLK_SOURCE_SELECT_O])
		else $error("running source not enabled");
	chk_mult_range: assert property (PLL_MULTIPLIER_O != 5'h00)
		else $error("multiplier zero");
	chk_pll_frozen: assert property (OSC_EN_O[4] && $past(OSC_EN_O[4]) |->
		$stable(PLL_MULTIPLIER_O) && $stable(PLL_SRC_O)) else $error("pll config moved");
	chk_pll_ref_on: assert property (OSC_EN_O[4] && PLL_SRC_O < 2'h2 |->
		OSC_EN_O[PLL_SRC_O]) else $error("pll reference disabled");
	// The lock input passes two sync flops before the request edge.
	chk_pll_locked: assert property ($changed(SYS_CLK_SOURCE_SELECT_O) &&
		SYS_CLK_SOURCE_SELECT_O == 3'h4 |-> $past(PLL_LOCK_I, 5)) else $error("pll unlocked");
	chk_nmi_fall: assert property (NMI_O |-> nmi_drop_s)
		else $error("bad fallback");
	chk_cpu_align: assert property (CPU_CORE_CLOCK_EN_O |->
		PERIPH_CLK_DOUBLE_EN_O && PERIPH_CLK_QUAD_EN_O) else $error("cpu enable misaligned");
	chk_double_align: assert property (PERIPH_CLK_DOUBLE_EN_O |-> PERIPH_CLK_QUAD_EN_O)
		else $error("double enable misaligned");
	chk_reset_state: assert property ($fell(RST_I) |-> fallback_s and !NMI_O)
		else $error("bad state after reset");
endmodule

bind clks_ctrl clks_ctrl_asserts chk_u (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I),
	.PLL_LOCK_I(PLL_LOCK_I), .SYS_CLK_SOURCE_SELECT_O(SYS_CLK_SOURCE_SELECT_O),
	.OSC_EN_O(OSC_EN_O), .PLL_SRC_O(PLL_SRC_O), .PLL_MULTIPLIER_O(PLL_MULTIPLIER_O),
	.PERIPH_CLK_QUAD_EN_O(PERIPH_CLK_QUAD_EN_O), .PERIPH_CLK_DOUBLE_EN_O(PERIPH_CLK_DOUBLE_EN_O),
	.CPU_CORE_CLOCK_EN_O(CPU_CORE_CLOCK_EN_O), .NMI_O(NMI_O));

// *** clks_ctrl_tb.sv ***
// Self-checking testbench for the clock controller.
`timescale 1ns/10ps
`include "clks_defs.svh"
module clks_ctrl_tb;
	logic clk, rst, psel, pen, pwr, lock, slp, pready, pslverr, nmi, q_en, d_en, c_en;
	logic [7:0] paddr, tick, cal2, cal32;
	logic [31:0] pwdata, prdata;
	logic [3:0] rdy;
	logic [2:0] sel;
	logic [4:0] osc_en, mult, m;
	logic [1:0] psrc;
	logic [32:0] expq[$];
	int err_total, compares, seed, n, qc, dc, cc;
	localparam logic [31:0] PC [0:2] = '{32'h07, 32'h0e, 32'h00};
	localparam logic [23:0] PE [0:2] = '{24'h201008, 24'h100404, 24'h404040};
	clks_ctrl dut_u (.SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .OSC_READY_I(rdy), .PLL_LOCK_I(lock),
		.SLEEP_OSC_STOP_I(slp), .RC2M_CLK_I(tick[1]), .RC32M_CLK_I(tick[0]),
		.RC32K_CLK_I(tick[6]), .LOW_FREQ_XTAL_IN_I(1'b0), .MAIN_XTAL_IN_I(tick[2]),
		.SYS_CLK_SOURCE_SELECT_O(sel), .OSC_EN_O(osc_en), .PLL_SRC_O(psrc),
		.PLL_MULTIPLIER_O(mult), .PERIPH_CLK_QUAD_EN_O(q_en), .PERIPH_CLK_DOUBLE_EN_O(d_en),
		.CPU_CORE_CLOCK_EN_O(c_en), .NMI_O(nmi), .DFLL2_CAL_O(cal2), .DFLL32_CAL_O(cal32));
	// The clock runs at 100 MHz.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Raw oscillator clocks come from a free counter so the loops see edges.
	always @(posedge clk) begin
		tick <= rst ? 8'h00 : tick + 8'h01;
	end
	task summarize();
		$display("mismatches %0d, compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task check(input logic [32:0] seen, input logic [32:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	// One transfer; keep leaves select up so a protected write follows at once.
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d, input bit keep);
		int i;
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i >= 20) begin
			err_total++;
			summarize();
		end
		if (!keep) begin
			psel <= 1'b0;
			pen <= 1'b0;
			@(posedge clk);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d, 1'b0);
	endtask
	task rd(input logic [7:0] a, input logic [32:0] e);
		expq.push_back(e);
		acc(1'b0, a, 32'h0, 1'b0);
	endtask
	// The key must be followed within four cycles by the guarded write.
	task key_wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, `CLKS_A_CCP, {24'h0, `CLKS_CCP_KEY}, 1'b1);
		acc(1'b1, a, d, 1'b0);
	endtask
	// Counts edges from the accepting access edge until the select output moves.
	task sw_wait(input logic [2:0] src);
		n = 1;
		while (sel !== src && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(33'(n), 33'h2);
		repeat (6) @(posedge clk);
	endtask
	// Read data is compared at the access edge, oldest note first.
	always @(posedge clk) begin
		if (psel && pen && !pwr && pready === 1'b1 && expq.size() > 0) begin
			check({pslverr, prdata}, expq.pop_front());
		end
	end
	initial begin
		seed = 89;
		{rst, psel, pen, pwr, lock, slp} = 6'b100000;
		{paddr, pwdata} = '0;
		rdy = 4'b0011;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		rd(`CLKS_A_SYSSEL, 33'h0);
		rd(`CLKS_A_OSCEN, 33'(`CLKS_OSC_EN_RST));
		rd(`CLKS_A_PLLCFG, 33'(`CLKS_PLL_MULT_RST));
		rd(`CLKS_A_D2CAL, 33'(`CLKS_CAL_RST));
		rd(`CLKS_A_D32COMP, 33'(`CLKS_COMP32_RST));
		rd(`CLKS_A_OSCSTAT, 33'h01);
		rd(8'h3c, 33'h100000000);
		wr(`CLKS_A_OSCEN, 32'h07);
		wr(`CLKS_A_SYSSEL, 32'h1);
		repeat (6) @(posedge clk);
		check({30'h0, sel}, 33'h0);
		key_wr(`CLKS_A_SYSSEL, 32'h2);
		repeat (6) @(posedge clk);
		check({30'h0, sel}, 33'h0);
		key_wr(`CLKS_A_SYSSEL, 32'h1);
		sw_wait(3'h1);
		rd(`CLKS_A_SYSSEL, 33'h1);
		wr(`CLKS_A_OSCEN, 32'h05);
		rd(`CLKS_A_OSCEN, 33'h07);
		// Reference is on and stable before the PLL is enabled.
		m = 5'($unsigned($random(seed)) % 31) + 5'h01;
		wr(`CLKS_A_PLLCFG, 32'(m));
		rd(`CLKS_A_PLLCFG, 33'(m));
		wr(`CLKS_A_PLLCFG, 32'h0);
		rd(`CLKS_A_PLLCFG, 33'(m));
		wr(`CLKS_A_OSCEN, 32'h17);
		wr(`CLKS_A_PLLCFG, 32'h41);
		rd(`CLKS_A_PLLCFG, 33'(m));
		wr(`CLKS_A_OSCEN, 32'h16);
		rd(`CLKS_A_OSCEN, 33'h17);
		key_wr(`CLKS_A_SYSSEL, 32'h4);
		repeat (6) @(posedge clk);
		check({30'h0, sel}, 33'h1);
		lock <= 1'b1;
		repeat (4) @(posedge clk);
		rd(`CLKS_A_OSCSTAT, 33'h13);
		key_wr(`CLKS_A_SYSSEL, 32'h4);
		sw_wait(3'h4);
		key_wr(`CLKS_A_FAILMON, 32'h2);
		lock <= 1'b0;
		n = 0;
		while (nmi !== 1'b1 && n < 10) begin
			@(posedge clk);
			#1;
			n++;
		end
		check({32'h0, nmi}, 33'h1);
		repeat (2) @(posedge clk);
		rd(`CLKS_A_SYSSEL, 33'h0);
		rd(`CLKS_A_OSCEN, 33'h01);
		rd(`CLKS_A_FAILMON, 33'h0a);
		key_wr(`CLKS_A_FAILMON, 32'h0);
		rd(`CLKS_A_FAILMON, 33'h0a);
		// Enable pulses are counted over 64 cycles, a multiple of every period.
		for (int i = 0; i < 3; i++) begin
			key_wr(`CLKS_A_PRESC, PC[i]);
			repeat (40) @(posedge clk);
			{qc, dc, cc} = '0;
			repeat (64) begin
				@(posedge clk);
				#1;
				qc += int'(q_en === 1'b1);
				dc += int'(d_en === 1'b1);
				cc += int'(c_en === 1'b1);
			end
			check({9'h0, qc[7:0], dc[7:0], cc[7:0]}, {9'h0, PE[i]});
		end
		key_wr(`CLKS_A_PRESC, 32'h54);
		rd(`CLKS_A_PRESC, 33'h0);
		wr(`CLKS_A_D2CAL, 32'h55);
		repeat (3) @(posedge clk);
		check({25'h0, cal2}, 33'h55);
		// The 2MHz stand-in runs slow against its compare value, so each full window trims up.
		wr(`CLKS_A_D2CTRL, 32'h1);
		wr(`CLKS_A_D2CAL, 32'h11);
		repeat (10240) @(posedge clk);
		check({25'h0, cal2}, 33'h56);
		slp <= 1'b1;
		repeat (5000) @(posedge clk);
		check({25'h0, cal2}, 33'h56);
		slp <= 1'b0;
		repeat (10240) @(posedge clk);
		check({25'h0, cal2}, 33'h57);
		wr(`CLKS_A_D2COMP, 32'h1234);
		rd(`CLKS_A_D2COMP, 33'(`CLKS_COMP2_RST));
		wr(`CLKS_A_D32COMP, 32'h1234);
		rd(`CLKS_A_D32COMP, 33'h1234);
		// The external stand-in counts as a fast clock, the only kind worth watching.
		key_wr(`CLKS_A_FAILMON, 32'h1);
		rdy <= 4'b1011;
		wr(`CLKS_A_OSCEN, 32'h09);
		rd(`CLKS_A_OSCSTAT, 33'h09);
		rdy <= 4'b0011;
		qc = 0;
		repeat (10) begin
			@(posedge clk);
			#1;
			qc += int'(nmi === 1'b1);
		end
		check(33'(qc), 33'h0);
		rd(`CLKS_A_OSCEN, 33'h01);
		rd(`CLKS_A_FAILMON, 33'h0b);
		// A second reset in mid-run must clear the sticky monitor enables.
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		rd(`CLKS_A_FAILMON, 33'h0);
		rd(`CLKS_A_D2CAL, 33'(`CLKS_CAL_RST));
		summarize();
	end
endmodule
